// [motor_lock_regs.vh]
// Register map, field positions, reset values and timing for motor_lock.
// Assumes Avalon-MM byte addressing, 32-bit data, one register per word.
`ifndef MOTOR_LOCK_REGS_VH
`define MOTOR_LOCK_REGS_VH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define REG_ADVANCE      4'h0
`define REG_ACCEL        4'h4
`define REG_LOCK_CFG     4'h8
`define REG_FAULT        4'hC
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ACCEL_THR_LSB    0
`define RES_SET_LSB      4
`define KT_SET_LSB       11
`define LOCK_EN_LSB      0
`define LOCK_THR_LSB     6
`define KT_WIN_LSB       9
`define FAULT_OCP_BIT    6
`define FAULT_HIZ_BIT    7
`define FAULT_DELAY_LSB  8
`define FAULT_ULIM_LSB   16
// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define LOCK_EN_RESET    6'h3F
`define ADVANCE_STEP_NS  2500
`define LOCK_OFF_CYCLES  5000
`define LOCK_EVAL_CYCLES 1000
`define NO_MOTOR_MA      140
`endif

// [advance_decode.v]
// Decodes the commutation advance code into a delay in nanoseconds.
// Pure combinational; caller registers the result.
`timescale 1ns/1ps
`include "motor_lock_regs.vh"
module advance_decode (
  input  wire [6:0]  advance_code,
  output wire [31:0] advance_delay_ns
);
  // Step of 2.5 us times value, shifted left by the shift field
  wire [3:0]  advance_value = advance_code[3:0];
  wire [2:0]  advance_shift = advance_code[6:4];
  wire [31:0] base_ns = advance_value * `ADVANCE_STEP_NS;
  assign advance_delay_ns = base_ns << advance_shift;
endmodule // advance_decode

// [motor_lock.v]
// Lock detection, current limit and fault handling for a sensorless
// three-phase driver. Analog measurements arrive as synchronous words
// from the sensing front end on mclk; registers over Avalon-MM.
//
// Notes on behaviour
// - Advance code decodes to delay in nanoseconds
// - Delay is 2.5us times value, shifted
// - Overcurrent shutdown always on, fixed threshold
// - Acceleration limit clamps amplitude, no fault
// - Ceiling is I times R plus speed times Kt
// - Acceleration limit only in closed loop
// - Six enable bits disable each detector
// - Six fault flags, cleared on restart
// - Flags set even when scheme disabled
// - Fault tri-states outputs after surge suppression
// - Restart automatically after lock-off interval
// - Low-side overcurrent trip sets flag zero
// - BEMF estimated from current and from speed
// - BEMF over amplitude for interval sets flag one
// - Measured Kt integrated per half cycle
// - Kt outside window for interval sets flag two
// - No current over 140 mA after handoff
// - No BEMF one cycle after handoff rate
// - Period doubling in closed loop is stuck
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "motor_lock_regs.vh"
module motor_lock #(
  parameter LOCK_OFF_CYCLES  = `LOCK_OFF_CYCLES,
  parameter LOCK_EVAL_CYCLES = `LOCK_EVAL_CYCLES,
  parameter OCP_THRESHOLD    = 16'hF000
) (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire        clk_en,
  // Avalon-MM slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Measurements from the sensing front end
  input  wire [15:0] phase_u_current_ma,
  input  wire [15:0] low_side_current_ma,
  input  wire [15:0] motor_speed,
  input  wire [15:0] output_amplitude,
  input  wire [15:0] speed_command,
  input  wire        closed_loop,
  input  wire        loop_handoff,
  input  wire        open_loop_rate_ok,
  input  wire        bemf_zero_cross,
  input  wire        half_cycle_end,
  input  wire [15:0] bemf_sample,
  input  wire [15:0] commutation_period,
  input  wire        period_done,
  input  wire        elec_cycle_end,
  // Towards the output stage
  output reg  [15:0] amplitude_limited,
  output reg         drive_enable,
  output reg         high_side_off,
  output reg         restart,
  output reg  [31:0] advance_delay_ns
);
  // --------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------
  localparam ST_RUN = 2'd0;
  localparam ST_SURGE = 2'd1;
  localparam ST_OFF = 2'd2;
  localparam SURGE_CYCLES = 8'd16;

  // Shift-over-value decode of a 7-bit setting
  function [31:0] sov;
    input [6:0] s;
    begin
      sov = {28'd0, s[3:0]} << s[6:4];
    end
  endfunction

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg  [6:0]  advance_code;
  reg  [3:0]  accel_limit_threshold;
  reg  [6:0]  winding_resistance_setting;
  reg  [6:0]  velocity_constant_setting;
  reg  [5:0]  lock_scheme_enables;
  reg  [2:0]  lock_current_threshold;
  reg  [1:0]  velocity_window_select;
  reg  [5:0]  fault_flags;
  reg         ocp_flag;
  reg  [1:0]  state;
  reg  [31:0] timer;
  reg  [15:0] eval_bemf_cnt;
  reg  [15:0] eval_kt_cnt;
  reg  [31:0] kt_accum;
  reg  [31:0] kt_measured;
  reg  [15:0] prev_period;
  reg         handoff_wait;
  reg         ol_watch;
  wire [31:0] next_delay;

  // Avalon answers in the same cycle
  assign avs_waitrequest = 1'b0;

  advance_decode u_adv (
    .advance_code     (advance_code),
    .advance_delay_ns (next_delay)
  );

  // --------------------------------------------------------------------
  // Estimates and thresholds
  // --------------------------------------------------------------------
  // Threshold current in mA: 250 mA steps, field value plus one, so zero gives 250 mA
  wire [31:0] threshold_current = ({28'd0, accel_limit_threshold} + 32'd1)
                                  * 32'd250;
  wire [31:0] lock_limit_ma = ({29'd0, lock_current_threshold} + 32'd1)
                              * 32'd1000;
  wire [31:0] r_val = sov(winding_resistance_setting);
  wire [31:0] kt_val = sov(velocity_constant_setting);
  // Ceiling uses programmed current and R plus measured speed, no measured current
  wire [31:0] u_limit = threshold_current * r_val
                        + {16'd0, motor_speed} * kt_val;
  // Two BEMF estimates: from current/resistance and from speed/Kt
  wire [31:0] ir_drop = {16'd0, phase_u_current_ma} * r_val;
  wire [31:0] bemf_from_current = ({16'd0, output_amplitude} > ir_drop) ?
    {16'd0, output_amplitude} - ir_drop : 32'd0;
  wire [31:0] bemf_from_speed = {16'd0, motor_speed} * kt_val;
  wire bemf_high = (bemf_from_current > {16'd0, output_amplitude}) ||
                   (bemf_from_speed > {16'd0, output_amplitude});
  // Kt window: quarter, eighth, sixteenth or half of nominal
  wire [31:0] kt_margin = (velocity_window_select == 2'd0) ? kt_val >> 2 :
                          (velocity_window_select == 2'd1) ? kt_val >> 3 :
                          (velocity_window_select == 2'd2) ? kt_val >> 4 :
                          kt_val >> 1;
  wire kt_out = (kt_measured < kt_val - kt_margin) ||
                (kt_measured > kt_val + kt_margin);

  // --------------------------------------------------------------------
  // Detector conditions
  // --------------------------------------------------------------------
  wire running = (state == ST_RUN);
  wire [5:0] detect;
  assign detect[0] = running &&
                     ({16'd0, low_side_current_ma} > lock_limit_ma);
  assign detect[1] = running &&
                     (eval_bemf_cnt == LOCK_EVAL_CYCLES[15:0]);
  assign detect[2] = running &&
                     (eval_kt_cnt == LOCK_EVAL_CYCLES[15:0]);
  assign detect[3] = running && handoff_wait && closed_loop &&
                     (phase_u_current_ma <= `NO_MOTOR_MA);
  assign detect[4] = running && ol_watch && elec_cycle_end &&
                     !bemf_zero_cross;
  assign detect[5] = running && closed_loop && period_done &&
                     (prev_period != 16'd0) &&
                     ({1'b0, commutation_period} >=
                      {prev_period, 1'b0});
  wire ocp_trip = running && (low_side_current_ma >= OCP_THRESHOLD);
  // Only enabled detectors stop the motor; overcurrent cannot be masked
  wire fault_event = |(detect & lock_scheme_enables)
                     || ocp_trip;

  // --------------------------------------------------------------------
  // Register writes and fault flags
  // --------------------------------------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      advance_code <= 7'h00;
      accel_limit_threshold <= 4'h0;
      winding_resistance_setting <= 7'h00;
      velocity_constant_setting <= 7'h00;
      lock_scheme_enables <= `LOCK_EN_RESET;
      lock_current_threshold <= 3'h7;
      velocity_window_select <= 2'h0;
      fault_flags <= 6'h00;
      ocp_flag <= 1'b0;
    end else if (clk_en) begin
      if (avs_write && avs_address == `REG_ADVANCE)
        advance_code <= avs_writedata[6:0];
      if (avs_write && avs_address == `REG_ACCEL) begin
        accel_limit_threshold <= avs_writedata[3:0];
        winding_resistance_setting <= avs_writedata[10:4];
        velocity_constant_setting <= avs_writedata[17:11];
      end
      if (avs_write && avs_address == `REG_LOCK_CFG) begin
        lock_scheme_enables <= avs_writedata[5:0];
        lock_current_threshold <= avs_writedata[8:6];
        velocity_window_select <= avs_writedata[10:9];
      end
      // Cleared on restart, but a detection in the same cycle wins
      if (restart) begin
        fault_flags <= detect;
        ocp_flag <= ocp_trip;
      end else begin
        fault_flags <= fault_flags | detect;
        ocp_flag <= ocp_flag | ocp_trip;
      end
    end
  end

  // Read mux, unmapped reads zero
  always @* begin
    case (avs_address)
      `REG_ADVANCE:  avs_readdata = {25'd0, advance_code};
      `REG_ACCEL:    avs_readdata = {14'd0, velocity_constant_setting,
                                     winding_resistance_setting,
                                     accel_limit_threshold};
      `REG_LOCK_CFG: avs_readdata = {21'd0, velocity_window_select,
                                     lock_current_threshold,
                                     lock_scheme_enables};
      `REG_FAULT:    avs_readdata = {u_limit[15:0], next_delay[15:8],
                                     !drive_enable, ocp_flag, fault_flags};
      default:       avs_readdata = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------
  // Evaluation counters and Kt integration
  // --------------------------------------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      eval_bemf_cnt <= 16'd0;
      eval_kt_cnt <= 16'd0;
      kt_accum <= 32'd0;
      kt_measured <= 32'd0;
      prev_period <= 16'd0;
      handoff_wait <= 1'b0;
      ol_watch <= 1'b0;
    end else if (clk_en) begin
      // Continuous condition over the interval; any break restarts it
      if (!running || !bemf_high)
        eval_bemf_cnt <= 16'd0;
      else if (eval_bemf_cnt != LOCK_EVAL_CYCLES[15:0])
        eval_bemf_cnt <= eval_bemf_cnt + 16'd1;
      if (!running || !closed_loop || !kt_out)
        eval_kt_cnt <= 16'd0;
      else if (eval_kt_cnt != LOCK_EVAL_CYCLES[15:0])
        eval_kt_cnt <= eval_kt_cnt + 16'd1;
      // Integral over a half electrical cycle is speed independent
      if (half_cycle_end) begin
        kt_measured <= kt_accum;
        kt_accum <= 32'd0;
      end else
        kt_accum <= kt_accum + {16'd0, bemf_sample};
      if (period_done)
        prev_period <= commutation_period;
      if (!closed_loop)
        prev_period <= 16'd0;
      // One check right after handoff to closed loop
      handoff_wait <= loop_handoff;
      // Watch one electrical cycle once the drive rate passes handoff
      if (!running || closed_loop || bemf_zero_cross)
        ol_watch <= 1'b0;
      else if (open_loop_rate_ok)
        ol_watch <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Shutdown, surge suppression and retry sequence
  // --------------------------------------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_RUN;
      timer <= 32'd0;
      drive_enable <= 1'b1;
      high_side_off <= 1'b0;
      restart <= 1'b0;
    end else if (clk_en) begin
      restart <= 1'b0;
      case (state)
        ST_RUN: begin
          if (fault_event) begin
            // High side first so winding energy decays via low side
            state <= ST_SURGE;
            high_side_off <= 1'b1;
            timer <= 32'd0;
          end
        end
        ST_SURGE: begin
          if (timer[7:0] == SURGE_CYCLES - 8'd1) begin
            state <= ST_OFF;
            drive_enable <= 1'b0;
            timer <= 32'd0;
          end else
            timer <= timer + 32'd1;
        end
        ST_OFF: begin
          if (timer == LOCK_OFF_CYCLES - 1) begin
            state <= ST_RUN;
            drive_enable <= 1'b1;
            high_side_off <= 1'b0;
            restart <= 1'b1;
          end else
            timer <= timer + 32'd1;
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Amplitude clamp and advance delay
  // --------------------------------------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      amplitude_limited <= 16'h0000;
      advance_delay_ns <= 32'h0000_0000;
    end else if (clk_en) begin
      // Clamp only; never touches the fault path
      if (closed_loop && ({16'd0, speed_command} > u_limit))
        amplitude_limited <= u_limit[15:0];
      else
        amplitude_limited <= speed_command;
      advance_delay_ns <= next_delay;
    end
  end
endmodule // motor_lock

// [lock_props.sv]
// Checker for the fault and advance outputs of motor_lock.
// Assumes one clock, mclk, and the asynchronous active-low arst_n.
`timescale 1ns/1ps
module lock_props #(
  parameter OCP_THRESHOLD = 16'hF000
) (
  input wire        mclk,
  input wire        arst_n,
  input wire        clk_en,
  input wire [15:0] low_side_current_ma,
  input wire        drive_enable,
  input wire        high_side_off,
  input wire        restart,
  input wire [31:0] advance_delay_ns
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Hi-Z only after the high side has been off for the surge window
  a_surge_before_hiz: assert property ($fell(drive_enable) |->
    high_side_off && $past(high_side_off, 15)) else $error("hi-Z early");
  a_hiz_high_off: assert property (!drive_enable |-> high_side_off)
    else $error("high side on while hi-Z");
  // Lock-off interval is far longer than eight cycles
  a_hiz_held: assert property ($fell(drive_enable) |=>
    !drive_enable [*8]) else $error("hi-Z left too soon");
  a_restart_rejoins: assert property ($rose(drive_enable) |->
    restart && !high_side_off) else $error("drive back without restart");
  a_restart_pulse: assert property (restart |=> !restart)
    else $error("restart longer than one cycle");
  a_restart_cause: assert property (restart |-> !$past(drive_enable))
    else $error("restart without hi-Z");
  // Overcurrent trips whatever the enables say
  a_ocp_trip: assert property (clk_en && drive_enable && !high_side_off &&
    low_side_current_ma > OCP_THRESHOLD |-> ##[1:2] high_side_off)
    else $error("overcurrent ignored");
  a_delay_step: assert property (advance_delay_ns % 32'h9C4 == 32'h0)
    else $error("delay not a step multiple");
  a_delay_max: assert property (advance_delay_ns <= 32'h493E00)
    else $error("delay above largest code");
endmodule // lock_props

bind motor_lock lock_props #(.OCP_THRESHOLD(OCP_THRESHOLD)) u_lock_props (
  .mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
  .low_side_current_ma(low_side_current_ma), .drive_enable(drive_enable),
  .high_side_off(high_side_off), .restart(restart),
  .advance_delay_ns(advance_delay_ns));

// [winding_model.sv]
// Behavioural windings: the currents the sensing front end reports.
// Assumes the bench picks a short level and whether a motor is present.
`timescale 1ns/1ps
module winding_model (
  input  wire        mclk,
  input  wire        drive_enable,
  input  wire [15:0] short_level,
  input  wire        connected,
  output reg  [15:0] phase_u_current_ma = 16'h0000,
  output reg  [15:0] low_side_current_ma = 16'h0000
);
  // Floating windings carry no current; a short replaces the load
  always @(posedge mclk) begin
    if (!drive_enable) begin
      phase_u_current_ma  <= 16'h0000;
      low_side_current_ma <= 16'h0000;
    end else begin
      phase_u_current_ma  <= connected ? 16'h01F4 : 16'h0000;
      low_side_current_ma <= (short_level != 16'h0000) ? short_level : 16'h01F4;
    end
  end
endmodule // winding_model

// [motor_lock_bench.sv]
// Self-checking bench for motor_lock with a winding model on its far side.
// Assumes the register map header and shortened lock intervals.
`timescale 1ns/1ps
`include "motor_lock_regs.vh"
module motor_lock_bench;
  localparam OFF_CYC = 50;
  reg         mclk, arst_n, clk_en, avs_read, avs_write, connected;
  reg  [3:0]  avs_address;
  reg  [31:0] avs_writedata, rd;
  wire [31:0] avs_readdata, advance_delay_ns;
  wire        avs_waitrequest, drive_enable, high_side_off, restart;
  wire [15:0] phase_u_current_ma, low_side_current_ma, amplitude_limited;
  reg  [15:0] motor_speed, output_amplitude, speed_command, bemf_sample;
  reg  [15:0] commutation_period, short_level;
  reg         closed_loop, loop_handoff, open_loop_rate_ok, bemf_zero_cross;
  reg         half_cycle_end, period_done, elec_cycle_end;
  integer     num_errors, tests_run, cycles, n, i;
  reg  [27:0] codes;

  motor_lock #(.LOCK_OFF_CYCLES(OFF_CYC), .LOCK_EVAL_CYCLES(20)) DUT (
    .mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .phase_u_current_ma(phase_u_current_ma),
    .low_side_current_ma(low_side_current_ma), .motor_speed(motor_speed),
    .output_amplitude(output_amplitude), .speed_command(speed_command),
    .closed_loop(closed_loop), .loop_handoff(loop_handoff),
    .open_loop_rate_ok(open_loop_rate_ok), .bemf_zero_cross(bemf_zero_cross),
    .half_cycle_end(half_cycle_end), .bemf_sample(bemf_sample),
    .commutation_period(commutation_period), .period_done(period_done),
    .elec_cycle_end(elec_cycle_end), .amplitude_limited(amplitude_limited),
    .drive_enable(drive_enable), .high_side_off(high_side_off),
    .restart(restart), .advance_delay_ns(advance_delay_ns));

  winding_model u_windings (.mclk(mclk), .drive_enable(drive_enable),
    .short_level(short_level), .connected(connected),
    .phase_u_current_ma(phase_u_current_ma),
    .low_side_current_ma(low_side_current_ma));

  // ------------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ------------------------------------------------------------------
  always #5 mclk = ~mclk;
  // Whole run is under a thousand cycles; a hang is cut well beyond that
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      test_done;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Bus tasks start just after an edge and end one edge after release
  task bus_cycle(input wr, input [3:0] a, input [31:0] d);
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) @(posedge mclk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
    end
  endtask
  // Waits for the trip, then for the retry, counting the hi-Z time
  task fault_cycle(input [31:0] flag_mask);
    begin
      n = 0;
      while (high_side_off !== 1'b1 && n < 100) begin
        @(posedge mclk);
        n = n + 1;
      end
      check(high_side_off, 1);
      bus_cycle(1'b0, `REG_FAULT, 32'h0);
      check(rd & flag_mask, flag_mask);
      short_level <= 16'h0000;
      connected <= 1'b1;
      // Surge window: high side off while the low side still conducts
      check(drive_enable, 1);
      repeat (14) @(posedge mclk);
      check(drive_enable, 0);
      n = 0;
      while (restart !== 1'b1 && n < 200) begin
        @(posedge mclk);
        n = n + 1;
      end
      check(n >= OFF_CYC - 2 && n <= OFF_CYC + 2, 1);
      repeat (2) @(posedge mclk);
      bus_cycle(1'b0, `REG_FAULT, 32'h0);
      check(rd & flag_mask, 32'h0);
    end
  endtask
  // Clamp to 250 mA x 2 + 100 x 1 in closed loop only, with no trip
  task accel_clamp;
    begin
      // Lock trip stays at 8 A, well above the 250 mA clamp
      bus_cycle(1'b1, `REG_ACCEL, 32'h820);
      bus_cycle(1'b1, `REG_LOCK_CFG, 32'h1FB);
      motor_speed <= 16'h0064;
      output_amplitude <= 16'hFFFF;
      speed_command <= 16'h03E8;
      repeat (30) @(posedge mclk);
      check(amplitude_limited, 32'h258);
      check(high_side_off, 0);
      closed_loop <= 1'b0;
      repeat (2) @(posedge mclk);
      check(amplitude_limited, 32'h3E8);
      closed_loop <= 1'b1;
    end
  endtask
  // Speed BEMF above amplitude, then measured Kt outside its window
  task bemf_kt_locks;
    begin
      bus_cycle(1'b1, `REG_LOCK_CFG, 32'h1C2);
      output_amplitude <= 16'h0032;
      fault_cycle(32'h02);
      output_amplitude <= 16'hFFFF;
      bus_cycle(1'b1, `REG_LOCK_CFG, 32'h1C4);
      fault_cycle(32'h04);
      // Nominal Kt of zero puts the measured value back in the window
      bus_cycle(1'b1, `REG_ACCEL, 32'h020);
    end
  endtask
  // Period doubling in closed loop, then no BEMF in open loop
  task stuck_locks;
    begin
      bus_cycle(1'b1, `REG_LOCK_CFG, 32'h1E0);
      commutation_period <= 16'h0064;
      period_done <= 1'b1;
      @(posedge mclk);
      commutation_period <= 16'h00C8;
      @(posedge mclk);
      period_done <= 1'b0;
      fault_cycle(32'h20);
      bus_cycle(1'b1, `REG_LOCK_CFG, 32'h1D0);
      closed_loop <= 1'b0;
      open_loop_rate_ok <= 1'b1;
      @(posedge mclk);
      elec_cycle_end <= 1'b1;
      @(posedge mclk);
      elec_cycle_end <= 1'b0;
      open_loop_rate_ok <= 1'b0;
      fault_cycle(32'h10);
    end
  endtask
  task test_done;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    {mclk, arst_n, avs_read, avs_write, closed_loop, loop_handoff} = 6'h00;
    {open_loop_rate_ok, bemf_zero_cross, half_cycle_end} = 3'h0;
    {period_done, elec_cycle_end} = 2'h0;
    {clk_en, connected} = 2'h3;
    {avs_address, avs_writedata, short_level} = 52'h0;
    {motor_speed, output_amplitude, speed_command} = 48'h0;
    {bemf_sample, commutation_period} = 32'h0;
    {num_errors, tests_run, cycles} = 0;
    codes = {7'h7F, 7'h18, 7'h01, 7'h00};
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    // Reset values and an unmapped place
    bus_cycle(1'b0, `REG_LOCK_CFG, 32'h0);
    check(rd, 32'h1FF);
    bus_cycle(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    // Advance codes: zero, smallest, first shifted and largest
    for (i = 0; i < 4; i = i + 1) begin
      bus_cycle(1'b1, `REG_ADVANCE, {25'h0, codes[i*7 +: 7]});
      bus_cycle(1'b0, `REG_ADVANCE, 32'h0);
      check(rd[6:0], codes[i*7 +: 7]);
      check(advance_delay_ns,
        (32'h9C4 * codes[i*7 +: 4]) << codes[i*7+4 +: 3]);
    end
    // Lock current trip, enabled: 10 A against an 8 A limit
    bus_cycle(1'b1, `REG_LOCK_CFG, 32'h1C9);
    short_level <= 16'h2710;
    fault_cycle(32'h01);
    // Same trip with its scheme disabled: flag only, drive stays on
    bus_cycle(1'b1, `REG_LOCK_CFG, 32'h1C8);
    short_level <= 16'h2710;
    repeat (10) @(posedge mclk);
    check(high_side_off, 0);
    bus_cycle(1'b0, `REG_FAULT, 32'h0);
    check(rd[0], 1);
    // Overcurrent with every scheme disabled still shuts down
    bus_cycle(1'b1, `REG_LOCK_CFG, 32'h1C0);
    short_level <= 16'hF100;
    fault_cycle(32'h40);
    // No motor at the loop handoff
    bus_cycle(1'b1, `REG_LOCK_CFG, 32'h1C8);
    connected <= 1'b0;
    closed_loop <= 1'b1;
    repeat (3) @(posedge mclk);
    loop_handoff <= 1'b1;
    @(posedge mclk);
    loop_handoff <= 1'b0;
    fault_cycle(32'h08);
    accel_clamp;
    bemf_kt_locks;
    stuck_locks;
    test_done;
  end
endmodule // motor_lock_bench
